// ===== design/sfpe_top.sv
// Summary of operation
// - fast read: 0bh, 24-bit address, dummy byte
// - read streams bytes while selected and clocked
// - read pointer wraps from top to zero
// - byte program 02h starts on select release
// - byte program to protected area ignored
// - word program: adh, address, even-odd bytes
// - later words: adh plus two data bytes
// - in word mode only adh, 05h, 04h and 0bh act
// - word program to protected area ignored
// - word mode exits at top, clears latch and word mode flag
// - 70h enables busy indication on output
// - busy shows on output while selected, in word mode only
// - 80h disables busy indication on output
// - sector erase 20h clears 4 KByte sector
// - block erase 52h clears 32 KByte block
// - block erase d8h clears 64 KByte block
// - erase of protected area is ignored
// - writes start only after select release
// - 06h sets the write enable latch
// - status read 05h works at any time
`timescale 1ns/100ps
module sfpe_top #(
  parameter int SECTOR_ERASE_CYCLES = sfpe_pkg::SE_CYC,
  parameter int BLOCK_ERASE_CYCLES  = sfpe_pkg::BE_CYC
) (
  // core clock and reset
  input  wire logic       core_clk_in,
  input  wire logic       nrst_in,
  // serial link
  input  wire logic       sck_in,
  input  wire logic       cs_n_in,
  input  wire logic       si_in,
  output logic            so_out,
  output logic            so_oe_out,
  // protection level
  input  wire logic [1:0] protect_in,
  // status
  output logic            busy_out,
  output logic            write_enable_latch_out,
  output logic            auto_increment_program_flag_out,
  output logic            so_busy_enable_out
);
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_PROG,
    ST_ERASE
  } sfpe_state_e;

  sfpe_state_e st_q;

  logic [7:0]  mem [0:sfpe_pkg::MEM_BYTES-1];

  logic [23:0] rd_addr_w;
  logic        rd_tgl_w;
  logic [7:0]  op_w;
  logic [23:0] addr_w;
  logic [7:0]  dat0_w;
  logic [7:0]  dat1_w;
  logic [2:0]  nb_w;
  logic        lk_so_w;
  logic        lk_oe_w;
  logic [7:0]  stat_w;

  logic [3:0]  sy_w;
  logic        cs_prev_q;
  logic        tgl_prev_q;
  logic        frm_q; // select carried serial clocks, so its frame words are new
  logic [7:0]  rd_data_q;
  logic        end_w;
  logic        cmd_w;

  logic        busy_q;
  logic        wel_q;
  logic        aai_q;
  logic        sobusy_q;
  logic [sfpe_pkg::TIMER_W-1:0] timer_q;
  logic [1:0]  wcnt_q;
  logic [24:0] pa_q;
  logic [15:0] pd_q;
  logic [23:0] er_q;
  logic [23:0] er_end_q;
  logic        er_act_q;
  logic        fin_w;

  logic        acc_bp_w;
  logic        acc_aai_w;
  logic        acc_er_w;
  logic [23:0] emask_w;
  logic [23:0] aai_base_w;

  // first address that the protection level covers
  function automatic logic [24:0] prot_limit(input logic [1:0] bp);
    case (bp)
      2'h0:    prot_limit = sfpe_pkg::MEM_LIMIT;
      2'h1:    prot_limit = sfpe_pkg::MEM_LIMIT - (sfpe_pkg::MEM_LIMIT >> 2);
      2'h2:    prot_limit = sfpe_pkg::MEM_LIMIT >> 1;
      default: prot_limit = 25'h0000000;
    endcase
  endfunction

  function automatic logic is_prot(input logic [23:0] a, input logic [1:0] bp);
    is_prot = ({1'b0, a & sfpe_pkg::ADDR_MASK} >= prot_limit(bp));
  endfunction

  sfpe_link u_link (
    .sck_in      (sck_in),
    .cs_n_in     (cs_n_in),
    .si_in       (si_in),
    .so_out      (lk_so_w),
    .so_oe_out   (lk_oe_w),
    .nrst_in     (nrst_in),
    .stat_in     (stat_w),
    .rd_data_in  (rd_data_q),
    .rd_addr_out (rd_addr_w),
    .rd_tgl_out  (rd_tgl_w),
    .op_out      (op_w),
    .addr_out    (addr_w),
    .dat0_out    (dat0_w),
    .dat1_out    (dat1_w),
    .nbytes_out  (nb_w)
  );

  // select, read request toggle and protection level into the core domain
  sfpe_sync #(.W(4)) u_core_sync (
    .clk_in  (core_clk_in),
    .nrst_in (nrst_in),
    .d_in    ({~cs_n_in, rd_tgl_w, protect_in}),
    .q_out   (sy_w)
  );

  assign stat_w = {1'b0, aai_q, 2'b00, sy_w[1:0], wel_q, busy_q};

  // link words are stable while deselected, so they are sampled directly
  assign end_w = cs_prev_q & ~sy_w[3];
  assign cmd_w = end_w && frm_q && st_q == ST_IDLE;
  assign fin_w = st_q != ST_IDLE && timer_q == '0 && wcnt_q == 2'h0 && !er_act_q;

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cs_prev_q  <= 1'b0;
      tgl_prev_q <= 1'b0;
      frm_q      <= 1'b0;
    end else begin
      cs_prev_q  <= sy_w[3];
      tgl_prev_q <= sy_w[2];
      frm_q      <= (sy_w[2] != tgl_prev_q) | (frm_q & ~end_w);
    end
  end

  // read fetch; the link only takes the byte eight serial clocks later
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) rd_data_q <= 8'h00;
    else if (sy_w[2] != tgl_prev_q) rd_data_q <= mem[rd_addr_w[sfpe_pkg::TOP_ADDRESS_BIT:0]];
  end

  always_comb begin
    case (op_w)
      sfpe_pkg::OP_SECTOR_ERASE:  emask_w = sfpe_pkg::SECTOR_MASK;
      sfpe_pkg::OP_BLOCK32_ERASE: emask_w = sfpe_pkg::BLOCK32_MASK;
      default:                    emask_w = sfpe_pkg::BLOCK64_MASK;
    endcase
  end

  assign aai_base_w = {addr_w[23:1], 1'b0};

  always_comb begin
    acc_bp_w  = 1'b0;
    acc_aai_w = 1'b0;
    acc_er_w  = 1'b0;
    if (cmd_w && wel_q) begin
      if (aai_q) begin
        acc_aai_w = op_w == sfpe_pkg::OP_AAI_WORD && nb_w >= sfpe_pkg::NB_AAI_NEXT;
      end else begin
        acc_bp_w = op_w == sfpe_pkg::OP_BYTE_PROGRAM && nb_w >= sfpe_pkg::NB_PROGRAM
                   && !is_prot(addr_w, sy_w[1:0]);
        acc_aai_w = op_w == sfpe_pkg::OP_AAI_WORD && nb_w >= sfpe_pkg::NB_AAI_FIRST
                    && !is_prot(aai_base_w | 24'h000001, sy_w[1:0]);
        acc_er_w = (op_w == sfpe_pkg::OP_SECTOR_ERASE || op_w == sfpe_pkg::OP_BLOCK32_ERASE
                    || op_w == sfpe_pkg::OP_BLOCK64_ERASE) && nb_w >= sfpe_pkg::NB_ERASE
                   && !is_prot(addr_w | emask_w, sy_w[1:0]);
      end
    end
  end

  // sequencer of self-timed operations
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_q     <= ST_IDLE;
      busy_q   <= 1'b0;
      timer_q  <= '0;
      wcnt_q   <= 2'h0;
      pa_q     <= 25'h0000000;
      pd_q     <= 16'hffff;
      er_q     <= 24'h000000;
      er_end_q <= 24'h000000;
      er_act_q <= 1'b0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (acc_bp_w) begin
            st_q    <= ST_PROG;
            busy_q  <= 1'b1;
            timer_q <= sfpe_pkg::TIMER_W'(sfpe_pkg::BP_CYC - 1);
            wcnt_q  <= 2'h1;
            pa_q    <= {1'b0, addr_w & sfpe_pkg::ADDR_MASK};
            pd_q    <= {8'hff, dat0_w};
          end else if (acc_aai_w) begin
            st_q    <= ST_PROG;
            busy_q  <= 1'b1;
            timer_q <= sfpe_pkg::TIMER_W'(sfpe_pkg::BP_CYC - 1);
            wcnt_q  <= 2'h2;
            if (aai_q) begin
              pd_q <= {addr_w[15:8], addr_w[23:16]};
            end else begin
              pa_q <= {1'b0, aai_base_w & sfpe_pkg::ADDR_MASK};
              pd_q <= {dat1_w, dat0_w};
            end
          end else if (acc_er_w) begin
            st_q     <= ST_ERASE;
            busy_q   <= 1'b1;
            timer_q  <= (op_w == sfpe_pkg::OP_SECTOR_ERASE)
                        ? sfpe_pkg::TIMER_W'(SECTOR_ERASE_CYCLES - 1)
                        : sfpe_pkg::TIMER_W'(BLOCK_ERASE_CYCLES - 1);
            er_q     <= addr_w & ~emask_w & sfpe_pkg::ADDR_MASK;
            er_end_q <= (addr_w | emask_w) & sfpe_pkg::ADDR_MASK;
            er_act_q <= 1'b1;
          end
        end
        ST_PROG: begin
          if (wcnt_q != 2'h0) begin
            wcnt_q <= wcnt_q - 2'h1;
            pa_q   <= pa_q + 25'h0000001;
            pd_q   <= {8'hff, pd_q[15:8]};
          end
          if (timer_q != '0) timer_q <= timer_q - 1'b1;
          if (fin_w) begin
            st_q   <= ST_IDLE;
            busy_q <= 1'b0;
          end
        end
        ST_ERASE: begin
          // sweep one byte a cycle; the timer always outlasts a block
          if (er_act_q) begin
            if (er_q == er_end_q) er_act_q <= 1'b0;
            else er_q <= er_q + 24'h000001;
          end
          if (timer_q != '0) timer_q <= timer_q - 1'b1;
          if (fin_w) begin
            st_q   <= ST_IDLE;
            busy_q <= 1'b0;
          end
        end
        default: begin
          st_q   <= ST_IDLE;
          busy_q <= 1'b0;
        end
      endcase
    end
  end

  // array has no reset; contents are unknown until erased
  always_ff @(posedge core_clk_in) begin
    if (st_q == ST_PROG && wcnt_q != 2'h0) begin
      mem[pa_q[sfpe_pkg::TOP_ADDRESS_BIT:0]] <= mem[pa_q[sfpe_pkg::TOP_ADDRESS_BIT:0]] & pd_q[7:0];
    end
    if (st_q == ST_ERASE && er_act_q) begin
      mem[er_q[sfpe_pkg::TOP_ADDRESS_BIT:0]] <= 8'hff;
    end
  end

  // latch, word mode and busy indication flags
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wel_q    <= 1'b0;
      aai_q    <= 1'b0;
      sobusy_q <= 1'b0;
    end else if (cmd_w) begin
      if (aai_q) begin
        if (op_w == sfpe_pkg::OP_WRITE_DISABLE && nb_w >= sfpe_pkg::NB_OPCODE) begin
          wel_q <= 1'b0;
          aai_q <= 1'b0;
        end
      end else if (nb_w >= sfpe_pkg::NB_OPCODE) begin
        case (op_w)
          sfpe_pkg::OP_WRITE_ENABLE:    wel_q <= 1'b1;
          sfpe_pkg::OP_WRITE_DISABLE:   wel_q <= 1'b0;
          sfpe_pkg::OP_SO_BUSY_ENABLE:  sobusy_q <= 1'b1;
          sfpe_pkg::OP_SO_BUSY_DISABLE: sobusy_q <= 1'b0;
          default: ;
        endcase
        if (acc_aai_w) aai_q <= 1'b1;
      end
    end else if (fin_w) begin
      if (!aai_q) begin
        wel_q <= 1'b0;
      end else if (pa_q >= prot_limit(sy_w[1:0])) begin
        wel_q <= 1'b0;
        aai_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      busy_out                        <= 1'b0;
      write_enable_latch_out          <= 1'b0;
      auto_increment_program_flag_out <= 1'b0;
      so_busy_enable_out              <= 1'b0;
    end else begin
      busy_out                        <= busy_q;
      write_enable_latch_out          <= wel_q;
      auto_increment_program_flag_out <= aai_q;
      so_busy_enable_out              <= sobusy_q;
    end
  end

  // ready/busy shows from the select edge itself, without waiting for sync
  assign so_out    = lk_oe_w ? lk_so_w : ~busy_q;
  assign so_oe_out = ~cs_n_in & (lk_oe_w | (sobusy_q & aai_q));

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);
  sequence s_cmd_end;
    cmd_w && !aai_q;
  endsequence
  sequence s_busy_run;
    busy_q [*8];
  endsequence
  a_wel_set: assert property (s_cmd_end and op_w == sfpe_pkg::OP_WRITE_ENABLE
    |=> wel_q)
    else $error("write enable did not set latch");

  a_no_wel_write: assert property (s_cmd_end and !wel_q |=> !busy_q)
    else $error("write started without latch");

  a_bp_start: assert property (acc_bp_w |=> s_busy_run)
    else $error("byte program not started or too short");

  a_bp_prot: assert property (s_cmd_end and op_w == sfpe_pkg::OP_BYTE_PROGRAM
    && is_prot(addr_w, sy_w[1:0]) |=> !busy_q)
    else $error("protected byte program started");

  a_erase_prot: assert property (s_cmd_end and op_w == sfpe_pkg::OP_SECTOR_ERASE
    && is_prot(addr_w | sfpe_pkg::SECTOR_MASK, sy_w[1:0]) |=> !busy_q)
    else $error("protected erase started");

  a_aai_only: assert property (cmd_w && aai_q && op_w == sfpe_pkg::OP_SO_BUSY_DISABLE
    |=> $stable(sobusy_q) && aai_q)
    else $error("invalid opcode acted on in word mode");

  a_wel_clear: assert property ($fell(busy_q) && !$past(aai_q) |-> !wel_q)
    else $error("latch not cleared after write");

  a_busy_end: assert property (fin_w |=> !busy_q && st_q == ST_IDLE)
    else $error("busy not cleared at finish");

  a_aai_top: assert property (fin_w && aai_q && pa_q >= prot_limit(sy_w[1:0])
    |=> !aai_q && !wel_q)
    else $error("word mode did not exit at top");

  a_rb_drive: assert property (sobusy_q && aai_q && !cs_n_in && !lk_oe_w
    |-> so_oe_out && so_out == !busy_q)
    else $error("ready busy not driven");
endmodule // sfpe_top

// ===== design/sfpe_pkg.sv
package sfpe_pkg;
  // array of the 2 Mbit density variant
  localparam int          MEM_BYTES       = 262144;
  localparam int          TOP_ADDRESS_BIT = 17;
  localparam logic [23:0] ADDR_MASK       = 24'h03ffff;
  localparam logic [24:0] MEM_LIMIT       = 25'h0040000;
  // opcodes
  localparam logic [7:0] OP_FAST_READ        = 8'h0b;
  localparam logic [7:0] OP_BYTE_PROGRAM     = 8'h02;
  localparam logic [7:0] OP_AAI_WORD         = 8'had;
  localparam logic [7:0] OP_STATUS_READ      = 8'h05;
  localparam logic [7:0] OP_WRITE_ENABLE     = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE    = 8'h04;
  localparam logic [7:0] OP_SO_BUSY_ENABLE   = 8'h70;
  localparam logic [7:0] OP_SO_BUSY_DISABLE  = 8'h80;
  localparam logic [7:0] OP_SECTOR_ERASE     = 8'h20;
  localparam logic [7:0] OP_BLOCK32_ERASE    = 8'h52;
  localparam logic [7:0] OP_BLOCK64_ERASE    = 8'hd8;
  // erase region size minus one, from the lowest select bit
  localparam logic [23:0] SECTOR_MASK  = 24'h000fff;
  localparam logic [23:0] BLOCK32_MASK = 24'h007fff;
  localparam logic [23:0] BLOCK64_MASK = 24'h00ffff;
  // frame byte positions and byte counts
  localparam logic [2:0] IDX_ADDR_LAST = 3'h3;
  localparam logic [2:0] IDX_DUMMY     = 3'h4;
  localparam logic [2:0] IDX_DATA      = 3'h5;
  localparam logic [2:0] IDX_MAX       = 3'h7;
  localparam logic [2:0] NB_OPCODE     = 3'h1;
  localparam logic [2:0] NB_ERASE      = 3'h4;
  localparam logic [2:0] NB_PROGRAM    = 3'h5;
  localparam logic [2:0] NB_AAI_FIRST  = 3'h6;
  localparam logic [2:0] NB_AAI_NEXT   = 3'h3;
  // status byte fields
  localparam int ST_BUSY = 0;
  localparam int ST_WEL  = 1;
  localparam int ST_BP   = 2;
  localparam int ST_AAI  = 6;
  // self-timed operations
  localparam int CORE_CLK_MHZ          = 100;
  localparam int BYTE_PROGRAM_TIME_US  = 20;
  localparam int SECTOR_ERASE_TIME_US  = 1000;
  localparam int BLOCK_ERASE_TIME_US   = 1000;
  localparam int BP_CYC = BYTE_PROGRAM_TIME_US * CORE_CLK_MHZ;
  localparam int SE_CYC = SECTOR_ERASE_TIME_US * CORE_CLK_MHZ;
  localparam int BE_CYC = BLOCK_ERASE_TIME_US * CORE_CLK_MHZ;
  localparam int TIMER_W = 20;
endpackage

// ===== design/sfpe_sync.sv
`timescale 1ns/100ps
module sfpe_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_in,
  input  wire logic         nrst_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meta_q <= '0;
      q_out  <= '0;
    end else begin
      meta_q <= d_in;
      q_out  <= meta_q;
    end
  end
endmodule // sfpe_sync

// ===== design/sfpe_link.sv
`timescale 1ns/100ps
module sfpe_link (
  // serial pins
  input  wire logic        sck_in,
  input  wire logic        cs_n_in,
  input  wire logic        si_in,
  output logic             so_out,
  output logic             so_oe_out,
  // core side
  input  wire logic        nrst_in,
  input  wire logic [7:0]  stat_in,
  input  wire logic [7:0]  rd_data_in,
  output logic      [23:0] rd_addr_out,
  output logic             rd_tgl_out,
  output logic      [7:0]  op_out,
  output logic      [23:0] addr_out,
  output logic      [7:0]  dat0_out,
  output logic      [7:0]  dat1_out,
  output logic      [2:0]  nbytes_out
);
  logic [2:0] bit_q;
  logic [2:0] idx_q;
  logic [6:0] sh_q;
  logic [7:0] out_q;
  logic [7:0] stat_s;
  logic [7:0] byte_w;
  logic [7:0] op_w;
  logic       done_w;

  assign byte_w = {sh_q, si_in};
  assign done_w = (bit_q == 3'h7);
  assign op_w   = (idx_q == 3'h0) ? byte_w : op_out;

  // status settles during the opcode byte, well before it is shifted out
  sfpe_sync #(.W(8)) u_stat_sync (
    .clk_in  (sck_in),
    .nrst_in (nrst_in),
    .d_in    (stat_in),
    .q_out   (stat_s)
  );

  always_ff @(posedge sck_in or posedge cs_n_in or negedge nrst_in) begin
    if (cs_n_in || !nrst_in) begin
      bit_q <= 3'h0;
      idx_q <= 3'h0;
    end else begin
      bit_q <= bit_q + 3'h1;
      if (done_w && idx_q != sfpe_pkg::IDX_MAX) idx_q <= idx_q + 3'h1;
    end
  end

  always_ff @(posedge sck_in or negedge nrst_in) begin
    if (!nrst_in) sh_q <= 7'h00;
    else sh_q <= byte_w[6:0];
  end

  // captured frame stays still while deselected, for the core to sample
  always_ff @(posedge sck_in or negedge nrst_in) begin
    if (!nrst_in) begin
      op_out     <= 8'h00;
      addr_out   <= 24'h000000;
      dat0_out   <= 8'h00;
      dat1_out   <= 8'h00;
      nbytes_out <= 3'h0;
    end else begin
      if (bit_q == 3'h0 && idx_q == 3'h0) nbytes_out <= 3'h0;
      if (done_w) begin
        if (idx_q != sfpe_pkg::IDX_MAX) nbytes_out <= idx_q + 3'h1;
        case (idx_q)
          3'h0: op_out <= byte_w;
          3'h1: addr_out[23:16] <= byte_w;
          3'h2: addr_out[15:8] <= byte_w;
          3'h3: addr_out[7:0] <= byte_w;
          3'h4: dat0_out <= byte_w;
          3'h5: dat1_out <= byte_w;
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge sck_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rd_addr_out <= 24'h000000;
      rd_tgl_out  <= 1'b0;
      out_q       <= 8'h00;
    end else if (done_w && op_w == sfpe_pkg::OP_FAST_READ
                 && idx_q == sfpe_pkg::IDX_ADDR_LAST) begin
      rd_addr_out <= {addr_out[23:8], byte_w} & sfpe_pkg::ADDR_MASK;
      rd_tgl_out  <= ~rd_tgl_out;
      out_q       <= 8'h00;
    end else if (done_w && op_w == sfpe_pkg::OP_FAST_READ
                 && idx_q >= sfpe_pkg::IDX_DUMMY) begin
      out_q       <= rd_data_in;
      rd_addr_out <= (rd_addr_out + 24'h000001) & sfpe_pkg::ADDR_MASK;
      rd_tgl_out  <= ~rd_tgl_out;
    end else if (done_w && op_w == sfpe_pkg::OP_STATUS_READ) begin
      out_q <= stat_s;
    end else begin
      out_q <= {out_q[6:0], 1'b0};
      // frame start toggles too, so the core can tell a clocked frame from a bare select
      if (bit_q == 3'h0 && idx_q == 3'h0) rd_tgl_out <= ~rd_tgl_out;
    end
  end

  // cleared on deselect, so a bare select shows ready/busy and not stale read data
  always_ff @(negedge sck_in or negedge nrst_in or posedge cs_n_in) begin
    if (!nrst_in || cs_n_in) begin
      so_out    <= 1'b0;
      so_oe_out <= 1'b0;
    end else begin
      so_out    <= out_q[7];
      so_oe_out <= (op_out == sfpe_pkg::OP_FAST_READ && idx_q >= sfpe_pkg::IDX_DATA)
                || (op_out == sfpe_pkg::OP_STATUS_READ && idx_q != 3'h0);
    end
  end
endmodule // sfpe_link

// ===== test/sfpe_host.sv
`timescale 1ns/100ps
module sfpe_host (
  // serial pins
  output logic      sck_out,
  output logic      cs_n_out,
  output logic      si_out,
  input  wire logic so_in
);
  logic [7:0] rx_q [10];

  initial begin
    sck_out = 1'b0;
    cs_n_out = 1'b1;
    si_out = 1'b1;
  end

  // select held over the whole frame, msb first, clock still between frames
  task automatic xfer(input logic [79:0] tx, input int n);
    #7.3 cs_n_out = 1'b0;
    for (int i = 0; i < n * 8; i++) begin
      si_out = tx[79 - i];
      #40 sck_out = 1'b1;
      rx_q[i / 8][7 - i % 8] = so_in;
      #40 sck_out = 1'b0;
    end
    #40 cs_n_out = 1'b1;
    // released line must not keep its last value
    si_out = ~si_out;
    #200;
  endtask

  // select only, to look at the ready or busy level
  task automatic peek(output logic v);
    #7.3 cs_n_out = 1'b0;
    #40 v = so_in;
    cs_n_out = 1'b1;
    #200;
  endtask
endmodule // sfpe_host

// ===== test/tb_spi_flash_program_erase_read.sv
`timescale 1ns/100ps
module tb_spi_flash_program_erase_read;
  logic       core_clk_in;
  logic       nrst_in;
  logic       sck, cs_n, si, so, so_oe, pk;
  logic [1:0] protect;
  logic       busy, write_enable_latch, auto_increment_program_flag, sbe;
  int         failures = 0;
  int         compares = 0;

  sfpe_top #(
    .SECTOR_ERASE_CYCLES(70000),
    .BLOCK_ERASE_CYCLES (70000)
  ) sfpe_top_inst (
    .core_clk_in                    (core_clk_in),
    .nrst_in                        (nrst_in),
    .sck_in                         (sck),
    .cs_n_in                        (cs_n),
    .si_in                          (si),
    .so_out                         (so),
    .so_oe_out                      (so_oe),
    .protect_in                     (protect),
    .busy_out                       (busy),
    .write_enable_latch_out         (write_enable_latch),
    .auto_increment_program_flag_out(auto_increment_program_flag),
    .so_busy_enable_out             (sbe)
  );

  sfpe_host sfpe_host_inst (
    .sck_out (sck),
    .cs_n_out(cs_n),
    .si_out  (si),
    .so_in   (so)
  );

  initial begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    if (failures == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic cmd(input logic [7:0] op);
    sfpe_host_inst.xfer({op, 72'h0}, 1);
    repeat (8) @(negedge core_clk_in);
  endtask

  // bounded wait; erase sweep is the longest case
  task automatic wait_busy(input logic lvl);
    for (int i = 0; i < 80000 && busy !== lvl; i++)
      @(negedge core_clk_in);
    chk({7'h0, busy}, {7'h0, lvl});
  endtask

  task automatic t_write_enable_cmd();
    cmd(8'h06);
    chk({7'h0, write_enable_latch}, 8'h01);
  endtask

  task automatic t_no_write_enable_cmd();
    sfpe_host_inst.xfer({8'h02, 24'h000040, 8'h00, 40'h0}, 5);
    repeat (20) @(negedge core_clk_in);
    chk({7'h0, busy}, 8'h00);
  endtask

  task automatic t_protect();
    logic [7:0] ops [4] = '{8'h02, 8'h20, 8'h52, 8'hd8};
    protect = 2'h3;
    foreach (ops[k]) begin
      t_write_enable_cmd();
      sfpe_host_inst.xfer({ops[k], 24'h000100, 48'h0}, (k == 0) ? 5 : 4);
      repeat (20) @(negedge core_clk_in);
      chk({7'h0, busy}, 8'h00);
    end
    cmd(8'h04);
    protect = 2'h0;
  endtask

  task automatic t_erase();
    t_write_enable_cmd();
    sfpe_host_inst.xfer({8'hd8, 24'h000123, 48'h0}, 4);
    wait_busy(1'b1);
    sfpe_host_inst.xfer({8'h05, 72'h0}, 2);
    chk(sfpe_host_inst.rx_q[1], 8'h03);
    wait_busy(1'b0);
    chk({7'h0, write_enable_latch}, 8'h00);
  endtask

  task automatic t_program_wrap();
    t_write_enable_cmd();
    sfpe_host_inst.xfer({8'h02, 24'h000000, 8'h5a, 40'h0}, 5);
    wait_busy(1'b1);
    wait_busy(1'b0);
    sfpe_host_inst.xfer({8'h0b, 24'h03ffff, 48'h0}, 8);
    chk(sfpe_host_inst.rx_q[6], 8'h5a);
    chk(sfpe_host_inst.rx_q[7], 8'hff);
  endtask

  task automatic t_word();
    logic [31:0] exp = 32'ha1b2c3d4;
    cmd(8'h70);
    chk({7'h0, sbe}, 8'h01);
    t_write_enable_cmd();
    sfpe_host_inst.xfer({8'had, 24'h000020, 8'ha1, 8'hb2, 32'h0}, 6);
    chk({7'h0, auto_increment_program_flag}, 8'h01);
    sfpe_host_inst.peek(pk);
    chk({7'h0, pk}, 8'h00);
    chk({7'h0, so_oe}, 8'h00);
    wait_busy(1'b0);
    sfpe_host_inst.peek(pk);
    chk({7'h0, pk}, 8'h01);
    sfpe_host_inst.xfer({8'h02, 24'h000040, 8'h00, 40'h0}, 5);
    repeat (20) @(negedge core_clk_in);
    chk({7'h0, busy}, 8'h00);
    cmd(8'h80);
    chk({7'h0, sbe}, 8'h01);
    sfpe_host_inst.xfer({8'had, 8'hc3, 8'hd4, 56'h0}, 3);
    wait_busy(1'b1);
    wait_busy(1'b0);
    cmd(8'h04);
    chk({6'h0, auto_increment_program_flag, write_enable_latch}, 8'h00);
    cmd(8'h80);
    chk({7'h0, sbe}, 8'h00);
    sfpe_host_inst.xfer({8'h0b, 24'h000020, 48'h0}, 9);
    for (int k = 0; k < 4; k++)
      chk(sfpe_host_inst.rx_q[5 + k], exp[31 - 8 * k -: 8]);
  endtask

  // upper quarter protected, so the word below it is the last one
  task automatic t_top_exit();
    protect = 2'h1;
    t_write_enable_cmd();
    sfpe_host_inst.xfer({8'had, 24'h02fffe, 8'h11, 8'h22, 32'h0}, 6);
    wait_busy(1'b1);
    wait_busy(1'b0);
    chk({6'h0, auto_increment_program_flag, write_enable_latch}, 8'h00);
    protect = 2'h0;
  endtask

  initial begin
    nrst_in = 1'b0;
    protect = 2'h0;
    repeat (16) @(negedge core_clk_in);
    nrst_in = 1'b1;
    repeat (4) @(negedge core_clk_in);
    chk({4'h0, auto_increment_program_flag, sbe, write_enable_latch, busy}, 8'h00);
    t_no_write_enable_cmd();
    t_protect();
    t_erase();
    t_program_wrap();
    t_word();
    t_top_exit();
    give_verdict();
  end

  // about 85k core cycles expected; hang cut at 100k
  initial begin
    #1000000;
    failures++;
    give_verdict();
  end
endmodule // tb_spi_flash_program_erase_read
